/* core/mpdu_pin_drv.sv */
`timescale 1ns/10ps
module mpdu_pin_drv
   import mpdu_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Port control
   mpdu_pin_if.drv port
);
   // Direction bit low drives the latch, high releases the pin
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         port.pin_out <= PORT_LATCH_RST;
         port.pin_oe <= 8'h00;
      end
      else
      begin
         port.pin_out <= port.latch; // RULE1
         port.pin_oe <= ~port.dir; // RULE1 RULE2
      end
   end
endmodule : mpdu_pin_drv

/* core/mpdu_pin_if.sv */
`timescale 1ns/10ps
interface mpdu_pin_if;
   logic [7:0] latch;
   logic [7:0] dir;
   logic [7:0] pin_out;
   logic [7:0] pin_oe;
   modport ctl (output latch, output dir, input pin_out, input pin_oe);
   modport drv (input latch, input dir, output pin_out, output pin_oe);
endinterface : mpdu_pin_if

/* core/mpdu_pkg.sv */
package mpdu_pkg;
   // ---------------------------------------------------------------
   // Direction register addresses in the special function space
   // ---------------------------------------------------------------
   localparam logic [7:0] PORT0_DIRECTION_ADDR = 8'hA4;
   localparam logic [7:0] PORT1_DIRECTION_ADDR = 8'hA5;
   localparam logic [7:0] PORT2_DIRECTION_ADDR = 8'hA6;
   localparam logic [7:0] PORT3_DIRECTION_ADDR = 8'hA7;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] PORT0_DIRECTION_RST = 8'hFF;
   localparam logic [7:0] PORT1_DIRECTION_RST = 8'hFF;
   localparam logic [7:0] PORT2_DIRECTION_RST = 8'h00;
   localparam logic [7:0] PORT3_DIRECTION_RST = 8'hFF;
   localparam logic [7:0] PORT_LATCH_RST = 8'hFF;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int P3_RXD_BIT = 0;
   localparam int P3_TXD_BIT = 1;
   localparam int P3_WR_BIT = 6;
   localparam int P3_RD_BIT = 7;
   localparam int TX_CLOCK_SEL_BIT = 4;
   localparam logic [1:0] PORT_COUNT = 2'h3;
   typedef enum logic {MPDU_CLK_TIMER1, MPDU_CLK_TIMER2} mpdu_clk_src_e;
endpackage : mpdu_pkg

/* core/mpdu_port_ctrl.sv */
`timescale 1ns/10ps
// Notes on behaviour
// RULE1: A cleared direction bit makes the pin an output driving the latch.
// RULE2: A set direction bit makes the pin an input and releases it.
// RULE3: Direction registers sit at 0xA4 to 0xA7 for ports 0 to 3.
// RULE4: Ports 0 and 2 carry the memory bus regardless of direction bits.
// RULE5: Port 1 pin 0 is only the timer 2 count input; software keeps it 1.
// RULE6: No timer 2 external capture or reload input exists.
// RULE7: Software must not enable timer 2 clock-out mode.
// RULE8: Port 3 pins 1 and 0 carry UART or general I/O per their bits.
// RULE9: Port 3 pins 3 and 2 are interrupt inputs; software keeps them 1.
// RULE10: Port 3 pins 5 and 4 are timer inputs; their bits stay 1.
// RULE11: Port 3 pins 7 and 6 are memory strobes, direction bits ignored.
// RULE12: The serial port has one baud clock for receive and transmit.
// RULE13: The transmit clock select bit picks timer 1 (0) or timer 2 (1).
// RULE14: A direction register reads back its last write or reset value.
module mpdu_port_ctrl
   import mpdu_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Special function register access
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   // Port latches from the core
   input wire logic [7:0] port1_latch,
   input wire logic [7:0] port3_latch,
   // Memory bus from the core
   input wire logic [7:0] mem_ad_out,
   input wire logic mem_ad_oe,
   input wire logic [7:0] mem_addr_hi,
   input wire logic mem_wr_n,
   input wire logic mem_rd_n,
   // Serial clock selection
   input wire logic [7:0] timer_two_control,
   input wire logic timer1_baud_tick,
   input wire logic timer2_baud_tick,
   output logic uart_baud_tick,
   output logic uart_clk_sel,
   // Pins
   input wire logic [7:0] p1_pin_in,
   input wire logic [7:0] p3_pin_in,
   output logic [7:0] p0_out,
   output logic [7:0] p0_oe,
   output logic [7:0] p1_out,
   output logic [7:0] p1_oe,
   output logic [7:0] p2_out,
   output logic [7:0] p2_oe,
   output logic [7:0] p3_out,
   output logic [7:0] p3_oe,
   output logic [7:0] p1_sync,
   output logic [7:0] p3_sync
);
   logic [7:0] port0_direction;
   logic [7:0] port1_direction;
   logic [7:0] port2_direction;
   logic [7:0] port3_direction;
   logic [7:0] p1_meta;
   logic [7:0] p3_meta;
   logic [7:0] drv3_out;
   logic [7:0] drv3_oe;
   logic [7:0] next_rdata;
   logic next_hit;
   logic [1:0] strobe_out;
   logic [1:0] strobe_oe;
   mpdu_pin_if p1_if ();
   mpdu_pin_if p3_if ();

   // ---------------------------------------------------------------
   // Direction registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         port0_direction <= PORT0_DIRECTION_RST;
         port1_direction <= PORT1_DIRECTION_RST;
         port2_direction <= PORT2_DIRECTION_RST;
         port3_direction <= PORT3_DIRECTION_RST;
      end
      else if (reg_wr)
      begin
         if (reg_addr == PORT0_DIRECTION_ADDR) // RULE3
            port0_direction <= reg_wdata;
         else if (reg_addr == PORT1_DIRECTION_ADDR)
            port1_direction <= reg_wdata;
         else if (reg_addr == PORT2_DIRECTION_ADDR)
            port2_direction <= reg_wdata;
         else if (reg_addr == PORT3_DIRECTION_ADDR)
            port3_direction <= reg_wdata;
      end
   end

   // Read data registered; other addresses belong to the core, hit low
   always_comb
   begin
      next_rdata = 8'h00;
      next_hit = 1'b1;
      if (reg_addr == PORT0_DIRECTION_ADDR)
         next_rdata = port0_direction; // RULE14
      else if (reg_addr == PORT1_DIRECTION_ADDR)
         next_rdata = port1_direction; // RULE14
      else if (reg_addr == PORT2_DIRECTION_ADDR)
         next_rdata = port2_direction; // RULE14
      else if (reg_addr == PORT3_DIRECTION_ADDR)
         next_rdata = port3_direction; // RULE14
      else
         next_hit = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         reg_rdata <= 8'h00;
         reg_hit <= 1'b0;
      end
      else
      begin
         reg_rdata <= reg_rd ? next_rdata : 8'h00;
         reg_hit <= reg_rd & next_hit;
      end
   end

   // ---------------------------------------------------------------
   // General ports through the shared pin driver
   // ---------------------------------------------------------------
   assign p1_if.latch = port1_latch;
   assign p1_if.dir = port1_direction;
   assign p3_if.latch = port3_latch;
   assign p3_if.dir = port3_direction;

   mpdu_pin_drv u_drv1 (.clk(clk), .srst(srst), .port(p1_if.drv));
   mpdu_pin_drv u_drv3 (.clk(clk), .srst(srst), .port(p3_if.drv));

   assign drv3_out = p3_if.pin_out;
   assign drv3_oe = p3_if.pin_oe;

   // Drivers are already registered, so these stay flop outputs
   always_comb
   begin
      p1_out = p1_if.pin_out; // RULE1
      p1_oe = p1_if.pin_oe; // RULE2
   end

   // ---------------------------------------------------------------
   // Memory bus and strobes ignore the direction registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         p0_out <= 8'h00;
         p0_oe <= 8'h00;
         p2_out <= 8'h00;
         p2_oe <= 8'hFF;
      end
      else
      begin
         p0_out <= mem_ad_out; // RULE4
         p0_oe <= {8{mem_ad_oe}}; // RULE4
         p2_out <= mem_addr_hi; // RULE4
         p2_oe <= 8'hFF; // RULE4
      end
   end

   // Strobes are idle high during reset so no memory is selected
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         strobe_out <= 2'h3;
         strobe_oe <= 2'h3;
      end
      else
      begin
         strobe_out <= {mem_rd_n, mem_wr_n}; // RULE11
         strobe_oe <= 2'h3; // RULE11
      end
   end

   // Pins 5..0 follow direction bits; UART pins 1..0 included.
   // One process builds each pin word so no bit has two writers.
   always_comb
   begin
      p3_out = {strobe_out, drv3_out[5:0]}; // RULE8 RULE11
      p3_oe = {strobe_oe, drv3_oe[5:0]}; // RULE8 RULE9 RULE10
   end

   // ---------------------------------------------------------------
   // Input synchronisers; no timer 2 external capture or reload input is provided
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         p1_meta <= 8'hFF;
         p1_sync <= 8'hFF;
         p3_meta <= 8'hFF;
         p3_sync <= 8'hFF;
      end
      else
      begin
         p1_meta <= p1_pin_in;
         p1_sync <= {7'h7F, p1_meta[0]}; // RULE5 RULE6
         p3_meta <= p3_pin_in;
         p3_sync <= p3_meta;
      end
   end

   // ---------------------------------------------------------------
   // Single serial clock for both directions
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         uart_clk_sel <= MPDU_CLK_TIMER1;
         uart_baud_tick <= 1'b0;
      end
      else
      begin
         uart_clk_sel <= timer_two_control[TX_CLOCK_SEL_BIT]; // RULE13
         uart_baud_tick <= timer_two_control[TX_CLOCK_SEL_BIT] ?
                           timer2_baud_tick : timer1_baud_tick; // RULE12
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   // Pins lag the direction register by the one driver flop
   property p_out_drive;
      @(posedge clk) disable iff (srst)
      !srst && !port1_direction[3] |=>
         p1_oe[3] && p1_out[3] == $past(port1_latch[3]);
   endproperty
   a_out_drive: assert property (p_out_drive) else $error("out drive"); // RULE1
   property p_in_release;
      @(posedge clk) disable iff (srst)
      !srst && port3_direction[2] |=> !p3_oe[2];
   endproperty
   a_in_release: assert property (p_in_release) else $error("release"); // RULE2
   property p_readback;
      @(posedge clk) disable iff (srst)
      reg_rd && reg_addr == PORT3_DIRECTION_ADDR |=>
         reg_hit && reg_rdata == $past(port3_direction);
   endproperty
   a_readback: assert property (p_readback) else $error("readback"); // RULE14
   property p_write_map;
      @(posedge clk) disable iff (srst)
      reg_wr && reg_addr == PORT1_DIRECTION_ADDR |=>
         port1_direction == $past(reg_wdata);
   endproperty
   a_write_map: assert property (p_write_map) else $error("write map"); // RULE3
   property p_p2_bus;
      @(posedge clk) disable iff (srst)
      !srst |=> p2_oe == 8'hFF && p2_out == $past(mem_addr_hi);
   endproperty
   a_p2_bus: assert property (p_p2_bus) else $error("p2 bus"); // RULE4
   property p_strobe;
      @(posedge clk) disable iff (srst)
      !srst |=> p3_oe[7:6] == 2'h3 && p3_out[7] == $past(mem_rd_n);
   endproperty
   a_strobe: assert property (p_strobe) else $error("strobe"); // RULE11
   property p_baud;
      @(posedge clk) disable iff (srst)
      !srst && timer_two_control[TX_CLOCK_SEL_BIT] |=>
         uart_baud_tick == $past(timer2_baud_tick);
   endproperty
   a_baud: assert property (p_baud) else $error("baud"); // RULE12
   property p_sel;
      @(posedge clk) disable iff (srst)
      !srst && !timer_two_control[TX_CLOCK_SEL_BIT] |=> !uart_clk_sel;
   endproperty
   a_sel: assert property (p_sel) else $error("clock select"); // RULE13
   property p_no_ext;
      @(posedge clk) disable iff (srst)
      ##2 1'b1 |-> p1_sync[1];
   endproperty
   a_no_ext: assert property (p_no_ext) else $error("ext input"); // RULE6
   c_write: cover property (@(posedge clk)
      reg_wr && reg_addr == PORT0_DIRECTION_ADDR);
   c_read: cover property (@(posedge clk) reg_hit);
   c_timer2: cover property (@(posedge clk) uart_clk_sel);
endmodule : mpdu_port_ctrl

/* test/mcu_port_direction_uart_clock_tb.sv */
`timescale 1ns/10ps
module mcu_port_direction_uart_clock_tb
   import mpdu_pkg::*;
;
   logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, reg_hit;
   logic mem_ad_oe = 0, mem_wr_n = 1, mem_rd_n = 1;
   logic timer1_baud_tick = 0, timer2_baud_tick = 0;
   logic uart_baud_tick, uart_clk_sel;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [7:0] port1_latch = 8'hFF, port3_latch = 8'hFF;
   logic [7:0] mem_ad_out = 8'h00, mem_addr_hi = 8'h00;
   logic [7:0] timer_two_control = 8'h00, ext1 = 8'hFF, ext3 = 8'hFF;
   logic [7:0] p1_pin_in, p3_pin_in, p0_out, p0_oe, p1_out, p1_oe;
   logic [7:0] p2_out, p2_oe, p3_out, p3_oe, p1_sync, p3_sync;
   logic [7:0] d, e_oe, e_out, tctl;
   logic [1:0] ticks;
   logic tsel;
   // Receive clock select position; software keeps it equal to transmit
   localparam int RX_CLOCK_SEL_BIT = 5;
   logic [7:0] dirs [4] = '{PORT0_DIRECTION_RST, PORT1_DIRECTION_RST,
      PORT2_DIRECTION_RST, PORT3_DIRECTION_RST};
   int n_errors = 0, check_count = 0, cycles = 0, k;
   int seed = 32'h8F60;

   always #25 clk = ~clk;

   mpdu_port_ctrl dut_u (.clk, .srst, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata, .reg_hit, .port1_latch, .port3_latch,
      .mem_ad_out, .mem_ad_oe, .mem_addr_hi, .mem_wr_n, .mem_rd_n,
      .timer_two_control, .timer1_baud_tick, .timer2_baud_tick,
      .uart_baud_tick, .uart_clk_sel, .p1_pin_in, .p3_pin_in, .p0_out,
      .p0_oe, .p1_out, .p1_oe, .p2_out, .p2_oe, .p3_out, .p3_oe,
      .p1_sync, .p3_sync);

   mpdu_far_model far_u (.p1_out, .p1_oe, .p3_out, .p3_oe, .ext1, .ext3,
      .p1_pin_in, .p3_pin_in);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] rnd8();
      return 8'($random(seed));
   endfunction : rnd8

   // Moves an address out of the direction block so the write is refused
   function automatic logic [7:0] off_map(input logic [7:0] a);
      return (a[7:2] == 6'h29) ? a ^ 8'h08 : a;
   endfunction : off_map

   task automatic check(input string name, input logic [7:0] seen,
                        input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic tally_and_finish();
      if (n_errors == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish

   task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   // A miss reads back zero beside a low hit flag
   task automatic reg_read(input logic [7:0] a, input logic [7:0] v,
                           input logic h);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      check("reg_rdata", reg_rdata, v);
      check("reg_hit", {7'h00, reg_hit}, {7'h00, h});
   endtask : reg_read

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_errors++;
         tally_and_finish();
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      #1;
      check("p0_oe", p0_oe, 8'h00);
      check("p2_oe", p2_oe, 8'hFF);
      check("p1_oe", p1_oe, 8'h00);
      check("p3_oe", p3_oe, 8'hC0);
      check("p3_out", p3_out, 8'hFF);
      for (int j = 0; j < 4; j++)
         reg_read(PORT0_DIRECTION_ADDR + 8'(j), dirs[j], 1'b1);
      for (int i = 0; i < 48; i++)
      begin
         k = i % 4;
         d = (i < 8) ? {8{i[2]}} : rnd8();
         if (k == 1)
            d[0] = 1'b1;
         if (k == 3)
            d[5:2] = 4'hF;
         dirs[k] = d;
         tctl = rnd8();
         tsel = tctl[TX_CLOCK_SEL_BIT];
         tctl[RX_CLOCK_SEL_BIT] = tsel;
         @(posedge clk);
         port1_latch <= rnd8();
         port3_latch <= rnd8();
         mem_ad_out <= rnd8();
         mem_addr_hi <= rnd8();
         {mem_ad_oe, mem_wr_n, mem_rd_n} <= 3'(rnd8());
         timer_two_control <= tctl;
         ext1 <= rnd8();
         ext3 <= rnd8();
         reg_write(off_map(rnd8()), rnd8());
         reg_write(PORT0_DIRECTION_ADDR + 8'(k), d);
         repeat (5) @(posedge clk);
         #1;
         e_oe = {2'b11, ~dirs[3][5:0]};
         e_out = {mem_rd_n, mem_wr_n, port3_latch[5:0]};
         check("p1_oe", p1_oe, ~dirs[1]);
         check("p1_out", p1_out & ~dirs[1], port1_latch & ~dirs[1]);
         check("p3_oe", p3_oe, e_oe);
         check("p3_out", p3_out & e_oe, e_out & e_oe);
         check("p0_oe", p0_oe, {8{mem_ad_oe}});
         check("p0_out", p0_out & p0_oe, mem_ad_out & p0_oe);
         check("p2_oe", p2_oe, 8'hFF);
         check("p2_out", p2_out, mem_addr_hi);
         check("p1_sync", p1_sync, {7'h7F, ext1[0]});
         check("p3_sync", p3_sync, (e_oe & e_out) | (~e_oe & ext3));
         check("uart_clk_sel", 8'(uart_clk_sel), 8'(tsel));
         ticks = 2'(rnd8());
         @(posedge clk);
         {timer2_baud_tick, timer1_baud_tick} <= ticks;
         @(posedge clk);
         {timer2_baud_tick, timer1_baud_tick} <= 2'b00;
         #1;
         check("uart_baud_tick", {7'h00, uart_baud_tick},
               {7'h00, ticks[tsel]});
         for (int j = 0; j < 4; j++)
            reg_read(PORT0_DIRECTION_ADDR + 8'(j), dirs[j], 1'b1);
         reg_read(off_map(rnd8()), 8'h00, 1'b0);
      end
      tally_and_finish();
   end
endmodule : mcu_port_direction_uart_clock_tb

/* test/mpdu_far_model.sv */
`timescale 1ns/10ps
module mpdu_far_model
(
   // Pad drivers of the block
   input wire logic [7:0] p1_out,
   input wire logic [7:0] p1_oe,
   input wire logic [7:0] p3_out,
   input wire logic [7:0] p3_oe,
   // Levels the outside circuits put on undriven pads
   input wire logic [7:0] ext1,
   input wire logic [7:0] ext3,
   // Resolved pad levels
   output logic [7:0] p1_pin_in,
   output logic [7:0] p3_pin_in
);
   // ---------------------------------------------------------------
   // Pad resolution
   // ---------------------------------------------------------------
   // Outside drivers only win where the block has let go of the pad
   always_comb
   begin
      p1_pin_in = (p1_oe & p1_out) | (~p1_oe & ext1);
      p3_pin_in = (p3_oe & p3_out) | (~p3_oe & ext3);
   end
endmodule : mpdu_far_model
